// ### hdl/oneshot_pwm_timer_regs.svh
/*
  Register offsets, field positions, reset values and counts of the
  one-shot / PWM timer channel.
  Assumes a 32-bit AHB-Lite slave port decoding byte offsets.
*/
//
// Function
// - One-shot counts down, reloads and halts.
// - One-shot retrigger reloads and restarts count.
// - One-shot starts on pin, overflow or flag.
// - Clearing count start flag stops counting.
// - One-shot interrupt when count reaches zero.
// - Input pin is port or trigger.
// - Output pin is port or pulse output.
// - Count register read value is undefined.
// - Stopped write loads reload and counter.
// - Running write loads reload register only.
// - PWM counts down, 16-bit or 8-bit.
// - PWM reloads at each rising edge.
// - PWM ignores triggers while counting.
// - 16-bit PWM: high n, period 65535.
// - 8-bit PWM: n*(m+1) high, 255*(m+1).
// - PWM starts on pin, overflow or flag.
`ifndef ONESHOT_PWM_TIMER_REGS_SVH
`define ONESHOT_PWM_TIMER_REGS_SVH

// =====================================================================
// Register byte offsets
`define TMR_CTRL_OFS      8'h00
`define TMR_COUNT_OFS     8'h04
`define TMR_STATUS_OFS    8'h08
`define TMR_MASK_OFS      8'h0C
`define TMR_PORT_OFS      8'h10

// =====================================================================
// Fields
`define TMR_CTRL_W        9
`define TMR_OS_START_BIT  9
`define TMR_STAT_W        2
`define TMR_STAT_ZERO     0
`define TMR_STAT_PWM_LOW  1
`define TMR_PORT_OUT_BIT  0
`define TMR_PORT_OE_BIT   1
`define TMR_PORT_IN_BIT   2

// =====================================================================
// Reset values
`define TMR_CTRL_RST      9'h000
`define TMR_COUNT_RST     16'h0000
`define TMR_STAT_RST      2'h0

// =====================================================================
// Counts
`define TMR_DIV8_LAST     5'h07
`define TMR_DIV32_LAST    5'h1F
`define TMR_PWM16_LAST    16'hFFFE
`define TMR_PWM8_LAST     16'h00FE

`endif

// ### hdl/oneshot_pwm_timer_pkg.sv
/*
  Types of the one-shot / PWM timer channel.
  Assumes the constants header is included by its users.
*/
package oneshot_pwm_timer_pkg;

  typedef enum logic [2:0] {
    ST_STOP = 3'b001,
    ST_WAIT = 3'b010,
    ST_RUN  = 3'b100
  } run_state_t;

  typedef enum logic [1:0] {
    CLK_UNDIV = 2'h0,
    CLK_DIV8  = 2'h1,
    CLK_DIV32 = 2'h2,
    CLK_SUB32 = 2'h3
  } clk_sel_t;

  // Control word, bit 0 is count_start.
  typedef struct packed {
    logic     out_en;
    logic     trig_edge;
    logic     trig_src;
    logic     trig_en;
    clk_sel_t clk_sel;
    logic     pwm8;
    logic     pwm_mode;
    logic     count_start;
  } ctrl_t;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
  } ahb_req_t;

endpackage

// ### hdl/oneshot_pwm_timer.sv
/*
  One-shot / PWM down-counting timer channel with an AHB-Lite slave.
  Assumes a single clock mclk; trigger pin and sub clock are
  asynchronous and pass two flip-flops first.
*/
// Our own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "oneshot_pwm_timer_regs.svh"

module oneshot_pwm_timer (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  output logic             irq,
  input  wire logic        trigger_in_pin,
  input  wire logic        sub_clk,
  input  wire logic        timer_overflow_in,
  output logic             pulse_out_pin,
  output logic             pulse_out_pin_oe
);

  // ===================================================================
  // Declarations
  oneshot_pwm_timer_pkg::ctrl_t      ctrl;
  oneshot_pwm_timer_pkg::run_state_t state;
  oneshot_pwm_timer_pkg::ahb_req_t   req;
  logic        req_valid;
  logic        wr_valid;
  logic [15:0] reload;
  logic [15:0] counter;
  logic [15:0] period;
  logic [7:0]  pre8;
  logic [7:0]  m_val;
  logic [`TMR_STAT_W-1:0] status;
  logic [`TMR_STAT_W-1:0] mask;
  logic [1:0]  port;
  logic        os_start;
  logic [1:0]  trig_sync;
  logic        trig_prev;
  logic [1:0]  sub_sync;
  logic        sub_prev;
  logic [4:0]  sys_pre;
  logic [4:0]  sub_pre;
  logic        sub_tick;
  logic        tick;
  logic        unit;
  logic        trigger;
  logic        pin_edge;
  logic        addr_ok;
  logic        rd_status;
  logic        ev_zero;
  logic        ev_pwm_low;
  logic        period_end;
  logic        start_run;
  logic [15:0] pwm_load;
  logic [15:0] pwm_last;

  function automatic logic hit(input logic [7:0] a,
                               input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // ===================================================================
  // AHB-Lite slave
  // Zero wait states; writes land in the data phase.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign addr_ok   = hsel && htrans[1] && hready;
  assign rd_status = addr_ok && !hwrite &&
                     hit(haddr[7:0], `TMR_STATUS_OFS);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      req_valid <= 1'b0;
      req       <= '0;
    end else begin
      req_valid <= addr_ok;
      req.wr    <= hwrite;
      req.addr  <= haddr[7:0];
    end
  end

  // Writes land at the edge that closes the data phase.
  assign wr_valid = req_valid && req.wr;

  // Read data is registered in the address phase.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      hrdata <= 32'h0000_0000;
      if (hit(haddr[7:0], `TMR_CTRL_OFS)) begin
        hrdata[`TMR_CTRL_W-1:0] <= ctrl;
      end
      if (hit(haddr[7:0], `TMR_COUNT_OFS)) begin
        // Software must not rely on this value.
        hrdata[15:0] <= counter;
      end
      if (hit(haddr[7:0], `TMR_STATUS_OFS)) begin
        hrdata[`TMR_STAT_W-1:0] <= status;
      end
      if (hit(haddr[7:0], `TMR_MASK_OFS)) begin
        hrdata[`TMR_STAT_W-1:0] <= mask;
      end
      if (hit(haddr[7:0], `TMR_PORT_OFS)) begin
        hrdata[1:0]              <= port;
        hrdata[`TMR_PORT_IN_BIT] <= trig_sync[1];
      end
    end
  end

  // ===================================================================
  // Control, mask and port registers
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl     <= `TMR_CTRL_RST;
      os_start <= 1'b0;
    end else begin
      os_start <= 1'b0;
      if (wr_valid && hit(req.addr, `TMR_CTRL_OFS)) begin
        ctrl     <= hwdata[`TMR_CTRL_W-1:0];
        os_start <= hwdata[`TMR_OS_START_BIT];
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mask <= `TMR_STAT_RST;
      port <= 2'h0;
    end else if (wr_valid) begin
      if (hit(req.addr, `TMR_MASK_OFS)) begin
        mask <= hwdata[`TMR_STAT_W-1:0];
      end
      if (hit(req.addr, `TMR_PORT_OFS)) begin
        port <= hwdata[1:0];
      end
    end
  end

  // ===================================================================
  // Status and interrupt
  // A new event in the cycle of a clearing read wins over the clear.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      status <= `TMR_STAT_RST;
    end else begin
      status <= (rd_status ? `TMR_STAT_RST : status) |
                {ev_pwm_low, ev_zero};
    end
  end

  assign irq = |(status & mask);

  // ===================================================================
  // Synchronisers
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      trig_sync <= 2'h0;
      trig_prev <= 1'b0;
      sub_sync  <= 2'h0;
      sub_prev  <= 1'b0;
    end else begin
      trig_sync <= {trig_sync[0], trigger_in_pin};
      trig_prev <= trig_sync[1];
      sub_sync  <= {sub_sync[0], sub_clk};
      sub_prev  <= sub_sync[1];
    end
  end

  // ===================================================================
  // Count clock selection
  // The sub clock is sampled on mclk, so it must run well below it.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sys_pre <= 5'h00;
      sub_pre <= 5'h00;
    end else begin
      sys_pre <= sys_pre + 5'h01;
      if (sub_sync[1] && !sub_prev) begin
        sub_pre <= sub_pre + 5'h01;
      end
    end
  end

  assign sub_tick = sub_sync[1] && !sub_prev &&
                    (sub_pre == `TMR_DIV32_LAST);

  always_comb begin
    unique case (ctrl.clk_sel)
      oneshot_pwm_timer_pkg::CLK_UNDIV: tick = 1'b1;
      oneshot_pwm_timer_pkg::CLK_DIV8:
        tick = (sys_pre[2:0] == `TMR_DIV8_LAST);
      oneshot_pwm_timer_pkg::CLK_DIV32:
        tick = (sys_pre == `TMR_DIV32_LAST);
      oneshot_pwm_timer_pkg::CLK_SUB32: tick = sub_tick;
    endcase
  end

  // ===================================================================
  // Trigger sources
  assign pin_edge = ctrl.trig_edge ? (trig_sync[1] && !trig_prev)
                                   : (!trig_sync[1] && trig_prev);
  // Without the trigger function the pin stays a port input.
  assign trigger = ctrl.trig_en &&
                   (ctrl.trig_src ? timer_overflow_in : pin_edge);

  // In one-shot mode a count starts on a trigger or on the os_start pulse.
  // In PWM mode the flag starts at once unless a trigger is awaited.
  assign start_run = ctrl.pwm_mode ?
                     (trigger || !ctrl.trig_en) :
                     (trigger || os_start);

  // ===================================================================
  // PWM timing
  // 8-bit mode: low byte prescales, high byte sets the width.
  assign pwm_load = ctrl.pwm8 ? {8'h00, reload[15:8]} : reload;
  assign pwm_last = ctrl.pwm8 ? `TMR_PWM8_LAST
                              : `TMR_PWM16_LAST;
  assign unit       = tick && (!ctrl.pwm8 || pre8 == m_val);
  assign period_end = unit && (period == pwm_last);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pre8 <= 8'h00;
    end else if (state != oneshot_pwm_timer_pkg::ST_RUN ||
                 (tick && pre8 == m_val)) begin
      pre8 <= 8'h00;
    end else if (tick) begin
      pre8 <= pre8 + 8'h01;
    end
  end

  // ===================================================================
  // Run state
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state <= oneshot_pwm_timer_pkg::ST_STOP;
    end else if (!ctrl.count_start) begin
      state <= oneshot_pwm_timer_pkg::ST_STOP;
    end else begin
      unique case (state)
        oneshot_pwm_timer_pkg::ST_STOP:
          state <= oneshot_pwm_timer_pkg::ST_WAIT;
        oneshot_pwm_timer_pkg::ST_WAIT:
          if (start_run) begin
            state <= oneshot_pwm_timer_pkg::ST_RUN;
          end
        oneshot_pwm_timer_pkg::ST_RUN:
          // A retrigger on the zero tick keeps the count alive.
          if (ev_zero && !(trigger || os_start)) begin
            state <= oneshot_pwm_timer_pkg::ST_WAIT;
          end
        default: state <= oneshot_pwm_timer_pkg::ST_STOP;
      endcase
    end
  end

  // One-shot end: the count reaches zero on this tick.
  assign ev_zero = !ctrl.pwm_mode && tick &&
                   state == oneshot_pwm_timer_pkg::ST_RUN &&
                   counter <= 16'h0001;
  assign ev_pwm_low = ctrl.pwm_mode && unit && !period_end &&
                      state == oneshot_pwm_timer_pkg::ST_RUN &&
                      counter == 16'h0001;

  // ===================================================================
  // Reload register and counter
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      reload <= `TMR_COUNT_RST;
    end else if (wr_valid && hit(req.addr, `TMR_COUNT_OFS)) begin
      reload <= hwdata[15:0];
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      counter <= `TMR_COUNT_RST;
      period  <= 16'h0000;
      m_val   <= 8'h00;
    end else if (state != oneshot_pwm_timer_pkg::ST_RUN) begin
      period <= 16'h0000;
      m_val  <= reload[7:0];
      if (wr_valid && hit(req.addr, `TMR_COUNT_OFS)) begin
        counter <= hwdata[15:0];
      end else if (ctrl.count_start && start_run &&
                   state == oneshot_pwm_timer_pkg::ST_WAIT) begin
        counter <= ctrl.pwm_mode ? pwm_load : reload;
      end
    end else if (ctrl.pwm_mode) begin
      // Triggers are not looked at while running.
      if (period_end) begin
        period  <= 16'h0000;
        counter <= pwm_load;
        m_val   <= reload[7:0];
      end else if (unit) begin
        period <= period + 16'h0001;
        if (counter != 16'h0000) begin
          counter <= counter - 16'h0001;
        end
      end
    end else if (trigger || os_start) begin
      counter <= reload;
    end else if (ev_zero) begin
      counter <= reload;
    end else if (tick) begin
      counter <= counter - 16'h0001;
    end
  end

  // ===================================================================
  // Output pin
  // PWM mode always owns the pin; one-shot output is optional.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pulse_out_pin    <= 1'b0;
      pulse_out_pin_oe <= 1'b0;
    end else if (ctrl.pwm_mode) begin
      pulse_out_pin_oe <= 1'b1;
      pulse_out_pin    <= state == oneshot_pwm_timer_pkg::ST_RUN &&
                          counter != 16'h0000;
    end else if (ctrl.out_en) begin
      pulse_out_pin_oe <= 1'b1;
      pulse_out_pin    <= state == oneshot_pwm_timer_pkg::ST_RUN &&
                          (!ev_zero || trigger || os_start);
    end else begin
      pulse_out_pin_oe <= port[`TMR_PORT_OE_BIT];
      pulse_out_pin    <= port[`TMR_PORT_OUT_BIT];
    end
  end

endmodule // oneshot_pwm_timer

// ### bench/oneshot_pwm_timer_sva.sv
/*
  Checker of the timer channel's bus answers and interrupt line.
  Assumes the one slave's hreadyout is fed back as hready.
*/
`timescale 1ns/1ps
`include "oneshot_pwm_timer_regs.svh"
module oneshot_pwm_timer_sva (
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        irq,
  input wire logic        trigger_in_pin,
  input wire logic        sub_clk,
  input wire logic        timer_overflow_in,
  input wire logic        pulse_out_pin,
  input wire logic        pulse_out_pin_oe
);
  default clocking dc @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // ==========
  // Assertions
  logic       rd_ph;
  logic       wr_ph;
  logic [7:0] ofs;
  assign ofs   = haddr[7:0];
  assign rd_ph = hsel && htrans[1] && hready && !hwrite;
  assign wr_ph = hsel && htrans[1] && hready && hwrite;
  a_reset_quiet: assert property ($rose(reset_n)
    |-> !irq && !pulse_out_pin_oe && hrdata == 32'h0)
    else $error("outputs not quiet after reset");
  a_resp_okay: assert property (hreadyout && !hresp)
    else $error("wait state or error response");
  a_read_hold: assert property (!$past(rd_ph) |-> $stable(hrdata))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (rd_ph && ofs > `TMR_PORT_OFS
    |=> hrdata == 32'h0) else $error("unmapped read not zero");
  a_ctrl_bits: assert property (rd_ph && ofs == `TMR_CTRL_OFS
    |=> hrdata[31:9] == 23'h0) else $error("control read too wide");
  a_status_bits: assert property (
    rd_ph && ofs == `TMR_STATUS_OFS |=> hrdata[31:2] == 30'h0)
    else $error("status read too wide");
  a_mask_bits: assert property (rd_ph && ofs == `TMR_MASK_OFS
    |=> hrdata[31:2] == 30'h0) else $error("mask read too wide");
  a_port_bits: assert property (
    rd_ph && ofs == `TMR_PORT_OFS |=> hrdata[31:3] == 29'h0)
    else $error("port read too wide");
  a_irq_drop: assert property ($fell(irq) |->
    $past(rd_ph && ofs == `TMR_STATUS_OFS)
    || $past(rd_ph && ofs == `TMR_STATUS_OFS, 2)
    || $past(wr_ph && ofs == `TMR_MASK_OFS, 2)
    || $past(wr_ph && ofs == `TMR_MASK_OFS, 3))
    else $error("interrupt dropped without read or mask");
  c_status_read: cover property (rd_ph && ofs == `TMR_STATUS_OFS && irq);
  c_pulse_end: cover property ($fell(pulse_out_pin));
  c_irq_rise: cover property ($rose(irq));
endmodule // oneshot_pwm_timer_sva

bind oneshot_pwm_timer oneshot_pwm_timer_sva oneshot_pwm_timer_sva_i (
  .mclk(mclk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .irq(irq), .trigger_in_pin(trigger_in_pin),
  .sub_clk(sub_clk), .timer_overflow_in(timer_overflow_in),
  .pulse_out_pin(pulse_out_pin), .pulse_out_pin_oe(pulse_out_pin_oe));

// ### bench/trig_load_model.sv
/*
  Far side: trigger source, free sub clock and a load that times pulses.
  Assumes fire pulses come from the bench.
*/
`timescale 1ns/1ps
module trig_load_model (
  input  wire logic mclk,
  input  wire logic fire,
  input  wire logic pin,
  output logic      trig,
  output logic      sub_clk,
  output int        hi_len,
  output int        per_len,
  output int        falls
);
  int   hc = 0;
  int   pc = 0;
  logic last = 1'b0;
  // ==========
  // Stimulus
  initial begin
    trig = 1'b0;
    hi_len = 0;
    per_len = 0;
    falls = 0;
    sub_clk = 1'b0;
    #3;
    forever #40 sub_clk = ~sub_clk;
  end
  always @(posedge fire) begin
    trig <= 1'b1;
    repeat (4) @(posedge mclk);
    trig <= 1'b0;
  end
  // ==========
  // Pulse timing
  always @(posedge mclk) begin
    last <= pin;
    hc <= pin ? hc + 1 : 0;
    pc <= (pin && !last) ? 1 : pc + 1;
    if (pin && !last) per_len <= pc;
    if (!pin && last) begin
      hi_len <= hc;
      falls <= falls + 1;
    end
  end
endmodule // trig_load_model

// ### bench/oneshot_pwm_timer_bench.sv
/*
  Self-checking bench of the one-shot / PWM timer channel.
  Assumes the design, checker and model are compiled first.
*/
`timescale 1ns/1ps
`include "oneshot_pwm_timer_regs.svh"
module oneshot_pwm_timer_bench;
  typedef struct packed {
    logic        w;
    logic [7:0]  a;
    logic [31:0] d;
  } row_t;
  logic        mclk = 1'b0, reset_n = 1'b0, fire = 1'b0, ovf = 1'b0;
  logic        hwrite = 1'b0, hready, hresp, irq, trig, sub_clk, pin, oe;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  int          hi_len, per_len, falls, f0, n_mismatch = 0, tests_run = 0;
  int          dv [4] = '{1, 8, 32, 512};
  row_t        rows [12] = '{'{1'b0, `TMR_CTRL_OFS, 32'h0},
    '{1'b0, `TMR_STATUS_OFS, 32'h0}, '{1'b0, `TMR_MASK_OFS, 32'h0},
    '{1'b1, `TMR_MASK_OFS, 32'hFFFFFFFF}, '{1'b0, `TMR_MASK_OFS, 32'h3},
    '{1'b1, 8'h14, 32'hFFFFFFFF}, '{1'b0, 8'h14, 32'h0},
    '{1'b1, `TMR_CTRL_OFS, 32'h3FE}, '{1'b0, `TMR_CTRL_OFS, 32'h1FE},
    '{1'b1, `TMR_CTRL_OFS, 32'h0}, '{1'b1, `TMR_PORT_OFS, 32'h3},
    '{1'b0, `TMR_PORT_OFS, 32'h3}};
  oneshot_pwm_timer oneshot_pwm_timer_i (
    .mclk(mclk), .reset_n(reset_n), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hresp(hresp),
    .hrdata(hrdata), .irq(irq), .trigger_in_pin(trig),
    .sub_clk(sub_clk), .timer_overflow_in(ovf),
    .pulse_out_pin(pin), .pulse_out_pin_oe(oe));
  trig_load_model trig_load_model_i (.mclk(mclk), .fire(fire),
    .pin(pin), .trig(trig), .sub_clk(sub_clk), .hi_len(hi_len),
    .per_len(per_len), .falls(falls));
  // ==========
  // Tasks
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge mclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  function automatic logic [31:0] ok(input int lo, input int hi);
    return {31'h0, hi_len >= lo && hi_len <= hi};
  endfunction
  // A wait that runs out is itself a mismatch, so a dead pin shows.
  task automatic wfall(input int lim);
    int f;
    f = falls;
    for (int i = 0; i < lim && falls == f; i++) @(posedge mclk);
    if (falls == f) chk("pulse end", 32'h0, 32'h1);
  endtask
  task automatic pulse();
    fire <= 1'b1;
    @(posedge mclk);
    fire <= 1'b0;
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ==========
  // Run
  initial begin
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    #300000;
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    repeat (6) @(posedge mclk);
    reset_n <= 1'b1;
    foreach (rows[i]) begin
      bus(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk("register", q, rows[i].d);
    end
    repeat (2) @(posedge mclk);
    chk("port oe", {31'h0, oe}, 32'h1);
    chk("port pin", {31'h0, pin}, 32'h1);
    bus(1'b1, `TMR_PORT_OFS, 32'h0);
    $display("test done: registers");
    bus(1'b1, `TMR_COUNT_OFS, 32'h3);
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, `TMR_CTRL_OFS, 32'h101 | (k << 3));
      bus(1'b1, `TMR_CTRL_OFS, 32'h301 | (k << 3));
      wfall(3000);
      chk("high", ok(2 * dv[k], 3 * dv[k] + 4), 32'h1);
      chk("irq", {31'h0, irq}, 32'h1);
      bus(1'b0, `TMR_STATUS_OFS, 32'h0);
      chk("status", q, 32'h1);
      chk("irq clear", {31'h0, irq}, 32'h0);
    end
    $display("test done: count clocks");
    for (int s = 0; s < 3; s++) begin
      bus(1'b1, `TMR_CTRL_OFS, (s == 2) ? 32'h121 : 32'h1A1 | (s << 6));
      f0 = falls;
      repeat (40) @(posedge mclk);
      chk("idle", falls, f0);
      {ovf, fire} <= (s == 1) ? 2'b10 : 2'b01;
      @(posedge mclk);
      {ovf, fire} <= 2'b00;
      if (s == 2) begin
        repeat (4) @(posedge mclk);
        chk("falling edge", {31'h0, pin}, 32'h0);
      end
      wfall(100);
      chk("start", ok(2, 7), 32'h1);
    end
    $display("test done: start sources");
    bus(1'b1, `TMR_CTRL_OFS, 32'h1A1);
    bus(1'b1, `TMR_COUNT_OFS, 32'h28);
    pulse();
    repeat (12) @(posedge mclk);
    pulse();
    wfall(200);
    chk("retrigger", ok(48, 62), 32'h1);
    pulse();
    repeat (8) @(posedge mclk);
    bus(1'b1, `TMR_COUNT_OFS, 32'h8);
    wfall(200);
    chk("running write", ok(38, 45), 32'h1);
    pulse();
    wfall(200);
    chk("new reload", ok(7, 12), 32'h1);
    $display("test done: retrigger");
    bus(1'b0, `TMR_STATUS_OFS, 32'h0);
    bus(1'b1, `TMR_COUNT_OFS, 32'h3E8);
    bus(1'b1, `TMR_CTRL_OFS, 32'h301);
    repeat (30) @(posedge mclk);
    chk("run pin", {31'h0, pin}, 32'h1);
    bus(1'b1, `TMR_CTRL_OFS, 32'h100);
    repeat (1100) @(posedge mclk);
    chk("stop pin", {31'h0, pin}, 32'h0);
    bus(1'b0, `TMR_STATUS_OFS, 32'h0);
    chk("stop status", q, 32'h0);
    $display("test done: stop");
    bus(1'b1, `TMR_COUNT_OFS, 32'h502);
    bus(1'b1, `TMR_CTRL_OFS, 32'h7);
    wfall(1000);
    wfall(1000);
    chk("pwm8 high", hi_len, 32'hF);
    chk("pwm8 period", per_len, 32'h2FD);
    chk("pwm oe", {31'h0, oe}, 32'h1);
    bus(1'b0, `TMR_STATUS_OFS, 32'h0);
    chk("pwm status", q, 32'h2);
    bus(1'b1, `TMR_CTRL_OFS, 32'h0);
    bus(1'b1, `TMR_COUNT_OFS, 32'h3);
    bus(1'b1, `TMR_CTRL_OFS, 32'h3);
    wfall(100);
    chk("pwm16 high", hi_len, 32'h3);
    $display("test done: pwm");
    bus(1'b1, `TMR_CTRL_OFS, 32'h0);
    bus(1'b1, `TMR_COUNT_OFS, 32'h500);
    bus(1'b1, `TMR_CTRL_OFS, 32'hA7);
    f0 = falls;
    repeat (600) @(posedge mclk);
    chk("pwm waits", falls, f0);
    pulse();
    wfall(100);
    repeat (50) @(posedge mclk);
    pulse();
    wfall(600);
    chk("pwm ignores", per_len, 32'hFF);
    $display("test done: pwm trigger");
    chk("irq before reset", {31'h0, irq}, 32'h1);
    reset_n <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("reset irq", {31'h0, irq}, 32'h0);
    chk("reset oe", {31'h0, oe}, 32'h0);
    chk("reset rdata", hrdata, 32'h0);
    reset_n <= 1'b1;
    bus(1'b0, `TMR_CTRL_OFS, 32'h0);
    chk("reset ctrl", q, 32'h0);
    $display("test done: reset");
    report_and_stop();
  end
endmodule // oneshot_pwm_timer_bench
